// >>> core/timer_toggle_status_irq.sv
/*
 * Output flop control, event status flags and interrupt mask of one
 * 16-bit timer channel, with its two compare registers.
 * Word-wide registers only; unmapped words read zero and drop writes.
 * Assumes the counter, prescaler and capture logic sit outside and
 * deliver one-cycle strobes on the core clock; all inputs synchronous.
 */
`timescale 1ns/1ps

// Notes on behaviour
// RQ1: capture-1 toggle enable set: each capture into register 1 inverts flop
// RQ2: capture-0 toggle enable set: each capture into register 0 inverts flop
// RQ3: compare-1 toggle enable set: counter equal compare 1 inverts flop
// RQ4: compare-0 toggle enable set: counter equal compare 0 inverts flop
// RQ5: command write: 00 invert, 01 set, 10 clear, 11 leave flop
// RQ6: command field always reads back as 11
// RQ7: counter overflow sets status bit 2
// RQ8: compare-1 match sets status bit 1
// RQ9: compare-0 match sets status bit 0
// RQ10: reading the status register clears its flags; writes cannot
// RQ11: interrupt request only for events whose mask bit is one
// RQ12: flags set on events whatever the mask says
// RQ13: mask bit 2 overflow, bit 1 compare 1, bit 0 compare 0
// RQ14: two 16-bit compare registers matched against the up-counter
// RQ15: control bits 7:6 read one, upper bits read zero
// RQ16: event in same cycle as status read keeps its flag set
// RQ17: coincident triggers invert once; software command wins that cycle
module timer_toggle_status_irq
    import timer_toggle_pkg::*;
(
    input  wire logic              i_core_clk,     // 40 MHz core clock
    input  wire logic              i_nrst,         // sync reset, low
    input  wire logic [ADDR_W-1:0] i_addr,         // register byte address
    input  wire logic [DATA_W-1:0] i_wdata,        // register write data
    input  wire logic              i_wr,           // write strobe
    input  wire logic              i_rd,           // read strobe
    input  wire logic [CNT_W-1:0]  i_counter,      // up-counter value
    input  wire logic              i_count_step,   // counter just advanced
    input  wire logic              i_overflow,     // counter overflow pulse
    input  wire logic              i_cap0_strobe,  // capture reg 0 loaded
    input  wire logic              i_cap1_strobe,  // capture reg 1 loaded
    output logic      [DATA_W-1:0] o_rdata,        // read data, next cycle
    output logic                   o_irq,          // interrupt level
    output logic                   o_toggle_flop   // timer output flop
);

    ////////////////////////////////////////////////////////////////////
    // declarations

    // register port request
    reg_req_t          req;

    // control, status and mask state
    toggle_en_t        toggle_en_q;
    event_bits_t       status_q;
    event_bits_t       status_d;
    event_bits_t       irq_en_q;
    event_bits_t       events;
    flop_command_t     cmd;

    // compare words and match pulses
    logic [CNT_W-1:0]  cmp0_value;
    logic [CNT_W-1:0]  cmp1_value;
    logic              cmp0_match;
    logic              cmp1_match;

    // address selects and qualified accesses
    logic              sel_ctrl;
    logic              sel_status;
    logic              sel_irq_en;
    logic              sel_cmp0;
    logic              sel_cmp1;
    logic              ctrl_wr;
    logic              status_rd;

    // output flop and interrupt
    logic              hw_toggle;
    logic              toggle_flop_q;
    logic              toggle_flop_d;
    logic              irq_q;

    // registered read data
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    ////////////////////////////////////////////////////////////////////
    // register port bundle and address decode

    // ports gathered into one request word
    assign req.addr  = i_addr;
    assign req.wdata = i_wdata;
    assign req.wr    = i_wr;
    assign req.rd    = i_rd;

    // one select per mapped word
    assign sel_ctrl   = (req.addr == OFS_TOGGLE_FLOP_CONTROL);
    assign sel_status = (req.addr == OFS_EVENT_STATUS);
    assign sel_irq_en = (req.addr == OFS_EVENT_IRQ_ENABLE);
    assign sel_cmp0   = (req.addr == OFS_COMPARE_REG_0);
    assign sel_cmp1   = (req.addr == OFS_COMPARE_REG_1);

    // qualified accesses
    assign ctrl_wr   = req.wr && sel_ctrl;
    assign status_rd = req.rd && sel_status;

    ////////////////////////////////////////////////////////////////////
    // compare registers and match detectors

    // both detectors share one step, so a value equal
    // to both words flags both in the same cycle
    compare_match u_cmp0 (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_wr_en    (req.wr && sel_cmp0),
        .i_wdata    (req.wdata[CNT_W-1:0]),
        .i_counter  (i_counter),
        .i_step     (i_count_step),
        .o_value_q  (cmp0_value),
        .o_match_q  (cmp0_match)
    );

    compare_match u_cmp1 (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_wr_en    (req.wr && sel_cmp1),
        .i_wdata    (req.wdata[CNT_W-1:0]),
        .i_counter  (i_counter),
        .i_step     (i_count_step),
        .o_value_q  (cmp1_value),
        .o_match_q  (cmp1_match)
    );

    ////////////////////////////////////////////////////////////////////
    // toggle enables, written through the control word

    // every control write loads the enables, a pure
    // command write too, so software rewrites the enables
    // it wants to keep beside each command
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            toggle_en_q <= TOGGLE_EN_RST;
        end else if (ctrl_wr) begin
            toggle_en_q.cap1_toggle_en <= req.wdata[POS_CAP1_TOGGLE_EN];
            toggle_en_q.cap0_toggle_en <= req.wdata[POS_CAP0_TOGGLE_EN];
            toggle_en_q.cmp1_toggle_en <= req.wdata[POS_CMP1_TOGGLE_EN];
            toggle_en_q.cmp0_toggle_en <= req.wdata[POS_CMP0_TOGGLE_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output flop: software command first, then hardware triggers

    // command is only live in the cycle of a control write
    // writing 11 leaves the flop to the hardware triggers
    assign cmd = ctrl_wr
               ? flop_command_t'(req.wdata[POS_FLOP_COMMAND +: 2])
               : CMD_KEEP;

    // any enabled trigger, merged so coincident ones invert once
    // overflow is not a trigger, only a flag source
    assign hw_toggle =
          (toggle_en_q.cap1_toggle_en && i_cap1_strobe)     // see RQ1
        | (toggle_en_q.cap0_toggle_en && i_cap0_strobe)     // see RQ2
        | (toggle_en_q.cmp1_toggle_en && cmp1_match)        // see RQ3
        | (toggle_en_q.cmp0_toggle_en && cmp0_match);       // see RQ4

    // next flop value: a command other than keep masks
    // every hardware trigger of the same cycle, so a set
    // or clear is never undone by a coincident capture
    always_comb begin
        case (cmd)
            CMD_INVERT: begin
                toggle_flop_d = ~toggle_flop_q;              // see RQ5
            end
            CMD_SET: begin
                toggle_flop_d = 1'b1;                        // see RQ5
            end
            CMD_CLEAR: begin
                toggle_flop_d = 1'b0;                        // see RQ5
            end
            CMD_KEEP: begin
                // hardware triggers act only without a command
                toggle_flop_d = toggle_flop_q ^ hw_toggle;   // see RQ17
            end
            default: begin
                toggle_flop_d = toggle_flop_q;
            end
        endcase
    end

    // the flop itself
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            toggle_flop_q <= TOGGLE_FLOP_RST;
        end else begin
            toggle_flop_q <= toggle_flop_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // event status flags

    // events gathered in status layout
    // compare pulses arrive one cycle after the step
    assign events.overflow = i_overflow;                     // see RQ7
    assign events.cmp1     = cmp1_match;                     // see RQ8
    assign events.cmp0     = cmp0_match;                     // see RQ9

    // read clears, new event wins, mask plays no part
    // the or after the clear keeps an event that meets a
    // read, so the next read still reports it
    always_comb begin
        status_d = status_q;
        if (status_rd) begin
            status_d = EVENT_RST;                            // see RQ10
        end
        status_d = status_d | events;                        // see RQ16 RQ12
    end

    // sticky flags, no write path
    // writes to the status word are dropped
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            status_q <= EVENT_RST;
        end else begin
            status_q <= status_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt mask

    // mask bits sit at their event positions
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            irq_en_q <= EVENT_RST;
        end else if (req.wr && sel_irq_en) begin
            irq_en_q.overflow <= req.wdata[POS_OVERFLOW_EVENT];  // see RQ13
            irq_en_q.cmp1     <= req.wdata[POS_CMP1_EVENT];      // see RQ13
            irq_en_q.cmp0     <= req.wdata[POS_CMP0_EVENT];      // see RQ13
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt level: only unmasked flags reach the cpu

    // registered, so the level trails a flag or mask change
    // by one cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & irq_en_q);                     // see RQ11
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data mux, unmapped words read zero

    // selects are exclusive, so at most one branch applies
    always_comb begin
        rdata_d = RDATA_RST;
        if (sel_ctrl) begin
            rdata_d[POS_CTRL_ONES +: 2]    = CTRL_ONES_RD;       // see RQ15
            rdata_d[POS_CAP1_TOGGLE_EN]    = toggle_en_q.cap1_toggle_en;
            rdata_d[POS_CAP0_TOGGLE_EN]    = toggle_en_q.cap0_toggle_en;
            rdata_d[POS_CMP1_TOGGLE_EN]    = toggle_en_q.cmp1_toggle_en;
            rdata_d[POS_CMP0_TOGGLE_EN]    = toggle_en_q.cmp0_toggle_en;
            rdata_d[POS_FLOP_COMMAND +: 2] = FLOP_COMMAND_RD;    // see RQ6
        end else if (sel_status) begin
            // value before this read's clear
            rdata_d[POS_OVERFLOW_EVENT] = status_q.overflow;
            rdata_d[POS_CMP1_EVENT]     = status_q.cmp1;
            rdata_d[POS_CMP0_EVENT]     = status_q.cmp0;
        end else if (sel_irq_en) begin
            rdata_d[POS_OVERFLOW_EVENT] = irq_en_q.overflow;
            rdata_d[POS_CMP1_EVENT]     = irq_en_q.cmp1;
            rdata_d[POS_CMP0_EVENT]     = irq_en_q.cmp0;
        end else if (sel_cmp0) begin
            rdata_d[CNT_W-1:0] = cmp0_value;
        end else if (sel_cmp1) begin
            rdata_d[CNT_W-1:0] = cmp1_value;
        end else begin
            rdata_d = RDATA_RST;
        end
    end

    // read data stands only in the cycle after the strobe
    // zero otherwise, so a stale word never looks like a reply
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            rdata_q <= RDATA_RST;
        end else if (req.rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= RDATA_RST;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops

    // plain copies, no logic after the registers
    assign o_rdata       = rdata_q;
    assign o_irq         = irq_q;
    assign o_toggle_flop = toggle_flop_q;

endmodule

// >>> core/timer_toggle_pkg.sv
/*
 * Shared constants and types for the timer output flop, event status
 * and interrupt mask block.
 * Assumes a 32-bit register port with byte addresses on word bounds.
 */
package timer_toggle_pkg;

    // register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;

    // register byte addresses
    localparam logic [7:0] OFS_TOGGLE_FLOP_CONTROL = 8'h00;
    localparam logic [7:0] OFS_EVENT_STATUS        = 8'h04;
    localparam logic [7:0] OFS_EVENT_IRQ_ENABLE    = 8'h08;
    localparam logic [7:0] OFS_COMPARE_REG_0       = 8'h0C;
    localparam logic [7:0] OFS_COMPARE_REG_1       = 8'h10;

    // toggle_flop_control field positions
    localparam int POS_FLOP_COMMAND   = 0;
    localparam int POS_CMP0_TOGGLE_EN = 2;
    localparam int POS_CMP1_TOGGLE_EN = 3;
    localparam int POS_CAP0_TOGGLE_EN = 4;
    localparam int POS_CAP1_TOGGLE_EN = 5;
    localparam int POS_CTRL_ONES      = 6;

    // event_status and event_irq_enable field positions
    localparam int POS_CMP0_EVENT     = 0;
    localparam int POS_CMP1_EVENT     = 1;
    localparam int POS_OVERFLOW_EVENT = 2;

    // fixed read values and reset values
    localparam logic [1:0]  CTRL_ONES_RD     = 2'h3;
    localparam logic [1:0]  FLOP_COMMAND_RD  = 2'h3;
    localparam logic [3:0]  TOGGLE_EN_RST    = 4'h0;
    localparam logic [2:0]  EVENT_RST        = 3'h0;
    localparam logic [15:0] COMPARE_RST      = 16'h0000;
    localparam logic        TOGGLE_FLOP_RST  = 1'b0;
    localparam logic [31:0] RDATA_RST        = 32'h0000_0000;

    // software command for the output flop
    typedef enum logic [1:0] {
        CMD_INVERT = 2'b00,
        CMD_SET    = 2'b01,
        CMD_CLEAR  = 2'b10,
        CMD_KEEP   = 2'b11
    } flop_command_t;

    // one bit per timer event, same layout for status and mask
    typedef struct packed {
        logic overflow;
        logic cmp1;
        logic cmp0;
    } event_bits_t;

    // toggle enables held in toggle_flop_control
    typedef struct packed {
        logic cap1_toggle_en;
        logic cap0_toggle_en;
        logic cmp1_toggle_en;
        logic cmp0_toggle_en;
    } toggle_en_t;

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

endpackage

// >>> core/compare_match.sv
/*
 * Compare register with its match detector for one timer channel.
 * Assumes the counter value is valid in the cycle of the step pulse.
 */
`timescale 1ns/1ps

module compare_match
    import timer_toggle_pkg::*;
(
    input  wire logic             i_core_clk,  // core clock
    input  wire logic             i_nrst,      // sync reset, low
    input  wire logic             i_wr_en,     // write compare value
    input  wire logic [CNT_W-1:0] i_wdata,     // new compare value
    input  wire logic [CNT_W-1:0] i_counter,   // up-counter value
    input  wire logic             i_step,      // counter shows new value
    output logic      [CNT_W-1:0] o_value_q,   // stored compare value
    output logic                  o_match_q    // one-cycle match pulse
);

    ////////////////////////////////////////////////////////////////////
    // compare value storage
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            o_value_q <= COMPARE_RST;
        end else if (i_wr_en) begin
            o_value_q <= i_wdata;  // see RQ14
        end
    end

    ////////////////////////////////////////////////////////////////////
    // match pulse, once per counter value
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            o_match_q <= 1'b0;
        end else begin
            o_match_q <= i_step && (i_counter == o_value_q);  // see RQ14
        end
    end

endmodule

// >>> test/timer_toggle_status_irq_asserts.sv
/*
 * Checker for the timer flop, event status and mask block.
 * Assumes it is bound to the top module and sees its ports only.
 */
`timescale 1ns/1ps

module timer_toggle_status_irq_asserts
    import timer_toggle_pkg::*;
(
    input wire logic              i_core_clk,    // core clock
    input wire logic              i_nrst,        // sync reset, low
    input wire logic [ADDR_W-1:0] i_addr,        // register address
    input wire logic [DATA_W-1:0] i_wdata,       // write data
    input wire logic              i_wr,          // write strobe
    input wire logic              i_rd,          // read strobe
    input wire logic              i_count_step,  // counter advanced
    input wire logic              i_overflow,    // overflow pulse
    input wire logic              i_cap0_strobe, // capture 0 loaded
    input wire logic              i_cap1_strobe, // capture 1 loaded
    input wire logic [DATA_W-1:0] o_rdata,       // read data
    input wire logic              o_irq,         // interrupt level
    input wire logic              o_toggle_flop  // output flop
);
    logic [3:0] en_q;     // shadow toggle enables
    logic [2:0] mask_q;   // shadow irq enables
    logic       step_q;   // count step one cycle back
    logic       ctrl_wr;  // control register write
    logic       mask_wr;  // mask register write

    // shadows follow the register writes
    assign ctrl_wr = i_wr && (i_addr == OFS_TOGGLE_FLOP_CONTROL);
    assign mask_wr = i_wr && (i_addr == OFS_EVENT_IRQ_ENABLE);
    always_ff @(posedge i_core_clk) begin
        en_q   <= !i_nrst ? 4'h0 : ctrl_wr ? i_wdata[5:2] : en_q;
        mask_q <= !i_nrst ? 3'h0 : mask_wr ? i_wdata[2:0] : mask_q;
        step_q <= i_nrst && i_count_step;
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    // status reads, plain and free of fresh events
    sequence rd_status;
        i_rd && i_addr == OFS_EVENT_STATUS;
    endsequence
    sequence quiet_read;
        rd_status ##0 (!i_overflow && !step_q);
    endsequence

    a_ctrl_fixed: assert property (
        i_rd && i_addr == OFS_TOGGLE_FLOP_CONTROL
            |=> o_rdata[31:6] == 26'h3 && o_rdata[1:0] == 2'h3)
        else $error("control read shows wrong fixed bits");
    a_cap_toggle: assert property (
        (i_cap0_strobe && en_q[2] || i_cap1_strobe && en_q[3]) && !ctrl_wr
            |=> o_toggle_flop != $past(o_toggle_flop))
        else $error("enabled capture did not invert the flop");
    a_cmd_invert: assert property (
        ctrl_wr && i_wdata[1:0] == CMD_INVERT |=> o_toggle_flop != $past(o_toggle_flop))
        else $error("invert command did not invert the flop");
    a_cmd_force: assert property (
        ctrl_wr && (i_wdata[1] ^ i_wdata[0]) |=> o_toggle_flop == $past(i_wdata[0]))
        else $error("set or clear command gave wrong flop");
    a_flop_quiet: assert property (
        !i_cap0_strobe && !i_cap1_strobe && !ctrl_wr && !step_q |=> $stable(o_toggle_flop))
        else $error("flop changed with no trigger");
    a_irq_mask: assert property (
        o_irq |-> $past(mask_q) != 3'h0)
        else $error("interrupt raised with all events masked");
    a_irq_overflow: assert property (
        i_overflow && mask_q[2] && !i_wr |-> ##2 o_irq)
        else $error("unmasked overflow raised no interrupt");
    a_read_clears: assert property (
        quiet_read ##1 rd_status |=> o_rdata[2:0] == 3'h0)
        else $error("status flags survived a read");
    a_keep_set: assert property (
        (rd_status ##0 i_overflow) ##1 rd_status |=> o_rdata[POS_OVERFLOW_EVENT])
        else $error("overflow lost when it met a status read");
endmodule

bind timer_toggle_status_irq timer_toggle_status_irq_asserts u_asserts (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_count_step(i_count_step), .i_overflow(i_overflow),
    .i_cap0_strobe(i_cap0_strobe), .i_cap1_strobe(i_cap1_strobe), .o_rdata(o_rdata),
    .o_irq(o_irq), .o_toggle_flop(o_toggle_flop)
);

// >>> test/test_timer_toggle_status_irq.sv
/*
 * Self-checking bench for the timer flop, event status and mask block.
 * Assumes the design package is compiled first; one 40 MHz clock.
 */
`timescale 1ns/1ps

module test_timer_toggle_status_irq
    import timer_toggle_pkg::*;
;
    logic              i_core_clk = 1'b0;  // core clock
    logic              i_nrst = 1'b0;      // sync reset, low
    reg_req_t          req = '0;           // register request
    logic [3:0]        ev_q = 4'h0;        // overflow, cap1, cap0, step
    logic [CNT_W-1:0]  cnt_q = '0;         // counter value
    logic [DATA_W-1:0] o_rdata;            // read data
    logic              o_irq;              // interrupt level
    logic              o_toggle_flop;      // output flop
    logic [DATA_W-1:0] exp_q[$];           // expected read data
    logic              rd_pend = 1'b0;     // read data due
    logic              m_flop = 1'b0;      // flop model
    logic [CNT_W-1:0]  cv[2];              // compare values
    logic [3:0]        evt[5] = '{4'h1, 4'h1, 4'h8, 4'h2, 4'h4};
    int                seed = 32'hF341;
    int                miscompares = 0;
    int                samples_checked = 0;
    int                cycles = 0;

    timer_toggle_status_irq uut (
        .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_addr(req.addr), .i_wdata(req.wdata),
        .i_wr(req.wr), .i_rd(req.rd), .i_counter(cnt_q), .i_count_step(ev_q[0]),
        .i_overflow(ev_q[3]), .i_cap0_strobe(ev_q[1]), .i_cap1_strobe(ev_q[2]),
        .o_rdata(o_rdata), .o_irq(o_irq), .o_toggle_flop(o_toggle_flop)
    );

    initial begin
        forever #12.5 i_core_clk = ~i_core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
        samples_checked++;
        if (seen !== want) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
        end
    endtask

    // one cycle of stimulus; on a read dat is the expected data
    task automatic cyc(input logic w, r, input logic [7:0] a, input logic [31:0] dat,
                       input logic [3:0] ev);
        @(posedge i_core_clk);
        req <= '{addr: a, wdata: dat, wr: w, rd: r};
        ev_q <= ev;
        cnt_q <= ev[0] ? dat[15:0] : 16'($random(seed));
        if (r)
            exp_q.push_back(dat);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        cyc(1'b1, 1'b0, a, dat, 4'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] dat);
        cyc(1'b0, 1'b1, a, dat, 4'h0);
    endtask

    task automatic idle(input int n);
        repeat (n) cyc(1'b0, 1'b0, 8'h00, 32'h0, 4'h0);
    endtask

    task automatic chk(input logic flop, input logic irq);
        idle(1);
        @(negedge i_core_clk);
        check({30'h0, o_irq, o_toggle_flop}, {30'h0, irq, flop});
    endtask

    // control write with readback; the model follows the command
    task automatic ctrl(input logic [31:0] dat);
        wr(OFS_TOGGLE_FLOP_CONTROL, dat);
        if (dat[1:0] == CMD_INVERT)
            m_flop = ~m_flop;
        else if (dat[1:0] != CMD_KEEP)
            m_flop = dat[0];
        chk(m_flop, 1'b0);
        rd(OFS_TOGGLE_FLOP_CONTROL, {24'h0, 2'h3, dat[5:2], 2'h3});
    endtask

    task automatic summarize();
        if (miscompares == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // read data is compared one cycle after each read strobe
    always @(posedge i_core_clk) rd_pend <= req.rd;
    always @(negedge i_core_clk) begin
        if (rd_pend)
            check(o_rdata, exp_q.pop_front());
    end

    // hang guard
    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cv[0] = 16'($random(seed));
        cv[1] = cv[0] ^ 16'h8000;
        repeat (8) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        // reset values, unmapped place, compare registers
        rd(OFS_TOGGLE_FLOP_CONTROL, 32'h0000_00C3);
        rd(OFS_EVENT_IRQ_ENABLE, 32'h0);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0);
        for (int i = 0; i < 2; i++) begin
            wr(i ? OFS_COMPARE_REG_1 : OFS_COMPARE_REG_0, {16'($random(seed)), cv[i]});
            rd(i ? OFS_COMPARE_REG_1 : OFS_COMPARE_REG_0, {16'h0, cv[i]});
        end
        // every command, then random enables and commands
        for (int c = 0; c < 8; c++)
            ctrl(c < 4 ? 32'(c) : 32'($random(seed)));
        // each event masked and unmasked, trigger off and on
        for (int k = 0; k < 5; k++) begin
            logic [31:0] fl;
            fl = (k < 3) ? (32'h1 << k) : 32'h0;
            wr(OFS_EVENT_IRQ_ENABLE, 32'h0);
            ctrl(32'h0000_0003);
            cyc(1'b0, 1'b0, 8'h00, {16'h0, cv[k % 2]}, evt[k]);
            idle(3);
            chk(m_flop, 1'b0);
            rd(OFS_EVENT_STATUS, fl);
            rd(OFS_EVENT_STATUS, 32'h0);
            wr(OFS_EVENT_IRQ_ENABLE, (k < 3) ? fl : 32'h7);
            rd(OFS_EVENT_IRQ_ENABLE, (k < 3) ? fl : 32'h7);
            ctrl(32'h0000_003F);
            cyc(1'b0, 1'b0, 8'h00, {16'h0, cv[k % 2]}, evt[k]);
            idle(3);
            m_flop = m_flop ^ (k != 2);
            chk(m_flop, k < 3);
            wr(OFS_EVENT_STATUS, 32'h0);
            rd(OFS_EVENT_STATUS, fl);
            rd(OFS_EVENT_STATUS, 32'h0);
            chk(m_flop, 1'b0);
        end
        // two captures together, then a set command beside a capture
        wr(OFS_EVENT_IRQ_ENABLE, 32'h0);
        cyc(1'b0, 1'b0, 8'h00, 32'h0, 4'h6);
        m_flop = ~m_flop;
        chk(m_flop, 1'b0);
        ctrl(32'h0000_003D);
        cyc(1'b1, 1'b0, OFS_TOGGLE_FLOP_CONTROL, 32'h0000_003D, 4'h2);
        chk(1'b1, 1'b0);
        // overflow in the cycle of a status read
        cyc(1'b0, 1'b1, OFS_EVENT_STATUS, 32'h0, 4'h8);
        rd(OFS_EVENT_STATUS, 32'h4);
        idle(2);
        summarize();
    end
endmodule
